// ===== logic/option_byte_config_decode.sv
// option byte store, reset latch and configuration decode
// assumes the programming port and strap come from the pin domain, the
// memory controller consumes the erase request and the gate signals
`timescale 1ns/1ps
module option_byte_config_decode
  import option_byte_pkg::*;
#(
  parameter bit         MASK_ROM      = 1'b0,
  parameter logic [7:0] FACTORY_BYTE0 = 8'hFF,
  parameter logic [7:0] FACTORY_BYTE1 = 8'hFF
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  // programming-mode port, asynchronous to pclk
  input  wire logic        prog_active,
  input  wire logic        prog_write,
  input  wire logic        prog_sel,
  input  wire logic [7:0]  prog_wdata,
  output logic [7:0]       prog_rdata,
  // program memory erase handshake
  output logic             erase_req,
  input  wire logic        erase_done,
  // external access gating
  input  wire logic        ext_prog_read_req,
  output logic             ext_prog_read_allow,
  input  wire logic        ext_eeprom_req,
  output logic             ext_eeprom_allow,
  // watchdog and halt
  input  wire logic        watchdog_active,
  input  wire logic        halt_entry,
  output logic             halt_reset_req,
  // decoded configuration
  output config_s          cfg,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr
);

  ////////////////////////////////////////////////////////////////////////
  // timing notes
  //
  // programming port
  // - all four tool pins pass two flops before any logic reads them
  // - a write is the synced rising edge of the strobe while active
  // - the store follows about three cycles after the strobe rises
  // - data and select must stand a few cycles around the strobe
  // - byte zero reserved bits always land as ones in the store
  // - mask parts ignore the port, the store stays erased
  //
  // reset latch
  // - the store is non-volatile: presetn never touches it
  // - live bytes sit at the erased value while presetn is low
  // - first edge after release copies store (or factory) to live
  // - live bytes, and so the decoded outputs, then hold until reset
  // - a tool write therefore shows on cfg only after the next reset
  //
  // erase handshake
  // - clearing stored protection starts a program memory erase
  // - the request stands until the memory reports done
  // - the store keeps the newly written byte through the erase
  //
  // register bus
  // - read-only window, setup phase registers the answer
  // - access phase always completes at once, pready tied high
  // - any write, and any unmapped offset, answers with an error
  //
  // hazards
  // - the decoded outputs are combinational from the live bytes, so a
  //   consumer that needs glitch-free levels should flop them itself
  // - an erase started just before reset is dropped with the reset;
  //   the memory side must tolerate a request that vanishes

  ////////////////////////////////////////////////////////////////////////
  // state

  typedef struct packed {
    logic [1:0]    act_sync;
    logic [1:0]    wr_sync;
    logic [1:0]    sel_sync;
    logic [15:0]   data_sync;
    logic          wr_prev;
    logic [7:0]    store0;
    logic [7:0]    store1;
    logic [7:0]    live0;
    logic [7:0]    live1;
    loader_state_e state;
    logic          erase;
    logic [31:0]   rdata;
    logic          slverr;
    logic          erase_seen;
  } state_s;

  // power-up value; the store part is never reset afterwards
  state_s st_reg = '{act_sync: 2'h0, wr_sync: 2'h0, sel_sync: 2'h0,
                     data_sync: 16'h0000, wr_prev: 1'b0,
                     store0: ERASED_BYTE, store1: ERASED_BYTE,
                     live0: ERASED_BYTE, live1: ERASED_BYTE,
                     state: ST_LOAD, erase: 1'b0,
                     rdata: 32'h00000000, slverr: 1'b0,
                     erase_seen: 1'b0};
  state_s st_next;

  ////////////////////////////////////////////////////////////////////////
  // decode helpers

  // oscillator code to source
  function automatic osc_source_e osc_decode(input logic [2:0] code);
    osc_source_e s;
    s = SRC_HIGH_SPEED;
    if (code == OSC_EXT_CLOCK) begin
      s = SRC_EXT_CLOCK;
    end else if (code == OSC_INT_RC) begin
      s = SRC_INT_RC;
    end else if (code[2:1] == OSC_EXT_RC_HI) begin
      s = SRC_EXT_RC;
    end else if (code == OSC_LP) begin
      s = SRC_LOW_POWER;
    end else if (code == OSC_MP) begin
      s = SRC_MED_POWER;
    end else if (code == OSC_MS) begin
      s = SRC_MED_SPEED;
    end else if (code == OSC_HS) begin
      s = SRC_HIGH_SPEED;
    end
    return s;
  endfunction

  // threshold code to level
  function automatic lvd_level_e lvd_decode(input logic [1:0] code);
    lvd_level_e l;
    unique case (code)
      LVT_OFF:  l = LVD_OFF;
      LVT_HIGH: l = LVD_HIGHEST;
      LVT_MED:  l = LVD_MEDIUM;
      LVT_LOW:  l = LVD_LOWEST;
    endcase
    return l;
  endfunction

  // forces reserved bits of byte zero to ones
  function automatic logic [7:0] fix_byte0(input logic [7:0] b);
    return {RESERVED_ONES, b[PKG_BIT:PROT_BIT]};
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // next state

  logic [7:0]  tool0;
  logic [7:0]  tool1;
  logic        tool_write;
  logic        apb_access;

  always_comb begin
    st_next = st_reg;
    // two-flop synchronisers on the programming pins
    st_next.act_sync  = {st_reg.act_sync[0], prog_active};
    st_next.wr_sync   = {st_reg.wr_sync[0], prog_write};
    st_next.sel_sync  = {st_reg.sel_sync[0], prog_sel};
    st_next.data_sync = {st_reg.data_sync[7:0], prog_wdata};
    st_next.wr_prev   = st_reg.wr_sync[1];
    tool_write = st_reg.act_sync[1] && st_reg.wr_sync[1]
                 && !st_reg.wr_prev;
    tool0 = st_reg.store0;
    tool1 = st_reg.store1;
    // only the programming port writes the store
    if (tool_write && !MASK_ROM) begin
      if (st_reg.sel_sync[1]) begin
        tool1 = st_reg.data_sync[15:8];
      end else begin
        // reserved bits forced high in case the tool slips
        tool0 = fix_byte0(st_reg.data_sync[15:8]);
      end
    end
    st_next.store0 = tool0;
    st_next.store1 = tool1;
    st_next.erase = 1'b0;
    unique case (st_reg.state)
      // latch once after reset factory values on mask parts
      ST_LOAD: begin
        st_next.live0 = MASK_ROM ? FACTORY_BYTE0 : st_reg.store0;
        st_next.live1 = MASK_ROM ? FACTORY_BYTE1 : st_reg.store1;
        st_next.state = ST_RUN;
      end
      // protection cleared by the tool starts an erase
      ST_RUN: begin
        if (tool_write && !MASK_ROM && !st_reg.sel_sync[1]
            && st_reg.store0[PROT_BIT]
            && !st_reg.data_sync[8 + PROT_BIT]) begin
          st_next.erase = 1'b1;
          st_next.state = ST_ERASE;
        end
      end
      // erase request held until the memory reports done
      ST_ERASE: begin
        st_next.erase = !erase_done;
        if (erase_done) begin
          st_next.erase_seen = 1'b1;
          st_next.state = ST_RUN;
        end
      end
      // unused code falls back to a fresh latch
      default: begin
        st_next.state = ST_LOAD;
      end
    endcase
    // apb slave: zero wait states, read-only window
    apb_access = psel && penable;
    st_next.slverr = 1'b0;
    if (psel && !penable) begin
      st_next.rdata = '0;
      unique case (paddr)
        CONFIG_OFFSET: st_next.rdata = {16'h0000, st_reg.live1,
                                        st_reg.live0};
        STATUS_OFFSET: st_next.rdata = {28'h0000000, 1'b0,
                                        st_reg.erase_seen, st_reg.erase,
                                        st_reg.state == ST_RUN};
        RAW_OFFSET:    st_next.rdata = 32'h00000000; // store not visible
        default:       st_next.slverr = 1'b1;
      endcase
      // store is never bus-writable
      if (pwrite) begin
        st_next.slverr = 1'b1;
      end
    end
    if (apb_access && !pwrite && paddr == RAW_OFFSET) begin
      st_next.slverr = st_reg.slverr;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // registers

  // erased content resets to all ones
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_reg.act_sync   <= 2'h0;
      st_reg.wr_sync    <= 2'h0;
      st_reg.sel_sync   <= 2'h0;
      st_reg.data_sync  <= 16'h0000;
      st_reg.wr_prev    <= 1'b0;
      st_reg.live0      <= ERASED_BYTE;
      st_reg.live1      <= ERASED_BYTE;
      st_reg.state      <= ST_LOAD;
      st_reg.erase      <= 1'b0;
      st_reg.rdata      <= 32'h00000000;
      st_reg.slverr     <= 1'b0;
      st_reg.erase_seen <= 1'b0;
    end else begin
      st_reg.act_sync   <= st_next.act_sync;
      st_reg.wr_sync    <= st_next.wr_sync;
      st_reg.sel_sync   <= st_next.sel_sync;
      st_reg.data_sync  <= st_next.data_sync;
      st_reg.wr_prev    <= st_next.wr_prev;
      st_reg.live0      <= st_next.live0;
      st_reg.live1      <= st_next.live1;
      st_reg.state      <= st_next.state;
      st_reg.erase      <= st_next.erase;
      st_reg.rdata      <= st_next.rdata;
      st_reg.slverr     <= st_next.slverr;
      st_reg.erase_seen <= st_next.erase_seen;
      // non-volatile store, starts erased and survives reset
      st_reg.store0     <= st_next.store0;
      st_reg.store1     <= st_next.store1;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // decoded outputs, all from latched bytes

  always_comb begin
    cfg.large_package          = st_reg.live0[PKG_BIT];
    cfg.readout_protect        = st_reg.live0[PROT_BIT];
    cfg.clock_monitor_enable   = !st_reg.live1[CLKMON_BIT];
    cfg.oscillator_select      =
      osc_decode(st_reg.live1[OSC_MSB:OSC_LSB]);
    cfg.low_power_resonator    = cfg.oscillator_select == SRC_LOW_POWER;
    cfg.medium_power_resonator = cfg.oscillator_select == SRC_MED_POWER;
    cfg.medium_speed_resonator = cfg.oscillator_select == SRC_MED_SPEED;
    cfg.high_speed_resonator   = cfg.oscillator_select == SRC_HIGH_SPEED;
    cfg.low_voltage_threshold  =
      lvd_decode(st_reg.live1[LVT_MSB:LVT_LSB]);
    cfg.lvd_enable             = cfg.low_voltage_threshold != LVD_OFF;
    cfg.halt_reset_enable      = st_reg.live1[HALT_BIT];
    cfg.watchdog_software_mode = st_reg.live1[WDSW_BIT];
    cfg.watchdog_forced_on     = !st_reg.live1[WDSW_BIT];
  end

  // access gating and halt reset
  assign ext_prog_read_allow = ext_prog_read_req
                               && !st_reg.live0[PROT_BIT];
  assign ext_eeprom_allow    = ext_eeprom_req;
  assign halt_reset_req      = halt_entry && watchdog_active
                               && st_reg.live1[HALT_BIT];
  assign erase_req           = st_reg.erase;

  // tool readback of the store only
  assign prog_rdata = st_reg.sel_sync[1] ? st_reg.store1 : st_reg.store0;

  // apb answer
  assign prdata  = st_reg.rdata;
  assign pready  = 1'b1;
  assign pslverr = psel && penable && st_reg.slverr;

endmodule

// ===== logic/option_byte_pkg.sv
// option byte layout, encodings and decoded configuration carriers
// assumes a single pclk domain and a small APB register window
package option_byte_pkg;

  localparam logic [7:0] ERASED_BYTE     = 8'hFF;
  localparam logic [5:0] RESERVED_ONES   = 6'h3F;
  localparam int         RES_MSB         = 7;
  localparam int         RES_LSB         = 2;
  localparam int         PKG_BIT         = 1;
  localparam int         PROT_BIT        = 0;
  localparam int         CLKMON_BIT      = 7;
  localparam int         OSC_MSB         = 6;
  localparam int         OSC_LSB         = 4;
  localparam int         LVT_MSB         = 3;
  localparam int         LVT_LSB         = 2;
  localparam int         HALT_BIT        = 1;
  localparam int         WDSW_BIT        = 0;

  // oscillator select codes
  localparam logic [2:0] OSC_EXT_CLOCK   = 3'h7;
  localparam logic [2:0] OSC_INT_RC      = 3'h6;
  localparam logic [1:0] OSC_EXT_RC_HI   = 2'h2;
  localparam logic [2:0] OSC_LP          = 3'h3;
  localparam logic [2:0] OSC_MP          = 3'h2;
  localparam logic [2:0] OSC_MS          = 3'h1;
  localparam logic [2:0] OSC_HS          = 3'h0;

  // low voltage threshold codes
  localparam logic [1:0] LVT_OFF         = 2'h3;
  localparam logic [1:0] LVT_HIGH        = 2'h2;
  localparam logic [1:0] LVT_MED         = 2'h1;
  localparam logic [1:0] LVT_LOW         = 2'h0;

  // register offsets and values
  localparam logic [11:0] CONFIG_OFFSET  = 12'h000;
  localparam logic [11:0] STATUS_OFFSET  = 12'h004;
  localparam logic [11:0] RAW_OFFSET     = 12'h008;

  typedef enum logic [2:0] {
    SRC_EXT_CLOCK, SRC_INT_RC, SRC_EXT_RC, SRC_LOW_POWER,
    SRC_MED_POWER, SRC_MED_SPEED, SRC_HIGH_SPEED
  } osc_source_e;

  typedef enum logic [1:0] {
    LVD_OFF, LVD_HIGHEST, LVD_MEDIUM, LVD_LOWEST
  } lvd_level_e;

  typedef enum logic [1:0] {
    ST_LOAD, ST_RUN, ST_ERASE
  } loader_state_e;

  // decoded static configuration
  typedef struct packed {
    logic        large_package;
    logic        readout_protect;
    logic        clock_monitor_enable;
    osc_source_e oscillator_select;
    logic        low_power_resonator;
    logic        medium_power_resonator;
    logic        medium_speed_resonator;
    logic        high_speed_resonator;
    lvd_level_e  low_voltage_threshold;
    logic        lvd_enable;
    logic        halt_reset_enable;
    logic        watchdog_software_mode;
    logic        watchdog_forced_on;
  } config_s;

  // programming-mode port from the external tool
  typedef struct packed {
    logic       active;
    logic       write;
    logic       sel;
    logic [7:0] data;
  } prog_req_s;

endpackage

// ===== verif/option_byte_monitor.sv
// concurrent checks on the option byte decoder ports
// assumes one pclk domain and asynchronous active-low presetn
`timescale 1ns/1ps
module option_byte_monitor
  import option_byte_pkg::*;
(
  input wire logic    pclk,
  input wire logic    presetn,
  input wire logic    erase_req,
  input wire logic    erase_done,
  input wire logic    ext_prog_read_req,
  input wire logic    ext_prog_read_allow,
  input wire logic    ext_eeprom_req,
  input wire logic    ext_eeprom_allow,
  input wire logic    watchdog_active,
  input wire logic    halt_entry,
  input wire logic    halt_reset_req,
  input wire config_s cfg,
  input wire logic    psel,
  input wire logic    penable,
  input wire logic    pwrite,
  input wire logic    pslverr
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  ////////////////////////////////////////////////////////////////////////
  // gating and decode relations
  property p_gate; ext_prog_read_allow == (ext_prog_read_req
    && !cfg.readout_protect); endproperty
  a_gate: assert property (p_gate) else $error("read gate wrong");
  property p_eeprom; ext_eeprom_allow == ext_eeprom_req; endproperty
  a_eeprom: assert property (p_eeprom) else $error("eeprom gated");
  property p_halt; halt_reset_req == (watchdog_active && halt_entry
    && cfg.halt_reset_enable); endproperty
  a_halt: assert property (p_halt) else $error("halt reset wrong");
  property p_wdog; cfg.watchdog_forced_on != cfg.watchdog_software_mode;
  endproperty
  a_wdog: assert property (p_wdog) else $error("watchdog mode");
  property p_lvd; cfg.lvd_enable == (cfg.low_voltage_threshold != LVD_OFF);
  endproperty
  a_lvd: assert property (p_lvd) else $error("detector enable");
  property p_lp; cfg.low_power_resonator
    == (cfg.oscillator_select == SRC_LOW_POWER); endproperty
  a_lp: assert property (p_lp) else $error("resonator flag");

  ////////////////////////////////////////////////////////////////////////
  // sequencing relations
  property p_hold; presetn && $past(presetn) && $past(presetn, 2)
    |-> $stable(cfg); endproperty
  a_hold: assert property (p_hold) else $error("config moved");
  property p_erase; erase_req && !erase_done |=> erase_req; endproperty
  a_erase: assert property (p_erase) else $error("erase dropped");
  property p_nowr; psel && penable && pwrite |-> pslverr; endproperty
  a_nowr: assert property (p_nowr) else $error("bus write taken");
endmodule

bind option_byte_config_decode option_byte_monitor option_byte_monitor_inst (
  .pclk(pclk), .presetn(presetn), .erase_req(erase_req),
  .erase_done(erase_done), .ext_prog_read_req(ext_prog_read_req),
  .ext_prog_read_allow(ext_prog_read_allow),
  .ext_eeprom_req(ext_eeprom_req), .ext_eeprom_allow(ext_eeprom_allow),
  .watchdog_active(watchdog_active), .halt_entry(halt_entry),
  .halt_reset_req(halt_reset_req), .cfg(cfg), .psel(psel),
  .penable(penable), .pwrite(pwrite), .pslverr(pslverr));

// ===== verif/option_byte_prog_tool.sv
// external programming tool driving the option byte port
// assumes pclk only paces the tool; the port itself is asynchronous
`timescale 1ns/1ps
module option_byte_prog_tool (
  input  wire logic pclk,
  output logic      prog_active,
  output logic      prog_write,
  output logic      prog_sel,
  output logic [7:0] prog_wdata
);
  initial begin
    prog_active = 1'b0;
    prog_write = 1'b0;
    prog_sel = 1'b0;
    prog_wdata = 8'h00;
  end

  // one byte: setup 4 cycles, strobe 4 cycles, idle 4 cycles
  task automatic write_byte(input logic act, input logic sel,
                            input logic [7:0] data);
    logic [7:0] d;
    d = sel ? data : {6'h3F, data[1:0]};
    @(posedge pclk);
    prog_active <= act;
    prog_sel <= sel;
    prog_wdata <= d;
    repeat (4) @(posedge pclk);
    prog_write <= 1'b1;
    repeat (4) @(posedge pclk);
    prog_write <= 1'b0;
    repeat (4) @(posedge pclk);
    prog_wdata <= ~d; // released bus shows no stale byte
  endtask
endmodule

// ===== verif/tb_option_byte_config_decode.sv
// self-checking bench for the option byte decoder
// assumes the tool model and the bound monitor are compiled alongside
`timescale 1ns/1ps
module tb_option_byte_config_decode
  import option_byte_pkg::*;
;
  logic pclk, presetn, erase_done, ext_prog_read_req, ext_eeprom_req;
  logic watchdog_active, halt_entry, psel, penable, pwrite, pready;
  logic prog_active, prog_write, prog_sel, erase_req, pslverr;
  logic ext_prog_read_allow, ext_eeprom_allow, halt_reset_req;
  logic [7:0]  prog_wdata, prog_rdata, b0, b1, cur0, cur1;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, r, d;
  logic        e;
  logic [2:0]  k;
  config_s     cfg;
  int          fails, total_checks;

  option_byte_prog_tool option_byte_prog_tool_inst (.pclk(pclk),
    .prog_active(prog_active), .prog_write(prog_write),
    .prog_sel(prog_sel), .prog_wdata(prog_wdata));
  option_byte_config_decode option_byte_config_decode_inst (.pclk(pclk),
    .presetn(presetn), .prog_active(prog_active), .prog_write(prog_write),
    .prog_sel(prog_sel), .prog_wdata(prog_wdata), .prog_rdata(prog_rdata),
    .erase_req(erase_req), .erase_done(erase_done),
    .ext_prog_read_req(ext_prog_read_req),
    .ext_prog_read_allow(ext_prog_read_allow),
    .ext_eeprom_req(ext_eeprom_req), .ext_eeprom_allow(ext_eeprom_allow),
    .watchdog_active(watchdog_active), .halt_entry(halt_entry),
    .halt_reset_req(halt_reset_req), .cfg(cfg), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr));

  ////////////////////////////////////////////////////////////////////////
  // helpers
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction

  // expected decode of a byte pair
  function automatic config_s exp_cfg(input logic [7:0] c0, c1);
    config_s c;
    osc_source_e src [8];
    lvd_level_e lv [4];
    src = '{SRC_HIGH_SPEED, SRC_MED_SPEED, SRC_MED_POWER, SRC_LOW_POWER,
            SRC_EXT_RC, SRC_EXT_RC, SRC_INT_RC, SRC_EXT_CLOCK};
    lv = '{LVD_LOWEST, LVD_MEDIUM, LVD_HIGHEST, LVD_OFF};
    c.large_package = c0[1];
    c.readout_protect = c0[0];
    c.clock_monitor_enable = !c1[7];
    c.oscillator_select = src[c1[6:4]];
    c.low_power_resonator = (c1[6:4] == 3'h3);
    c.medium_power_resonator = (c1[6:4] == 3'h2);
    c.medium_speed_resonator = (c1[6:4] == 3'h1);
    c.high_speed_resonator = (c1[6:4] == 3'h0);
    c.low_voltage_threshold = lv[c1[3:2]];
    c.lvd_enable = (c1[3:2] != 2'h3);
    c.halt_reset_enable = c1[1];
    c.watchdog_software_mode = c1[0];
    c.watchdog_forced_on = !c1[0];
    return c;
  endfunction

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp,
                     input string what);
    total_checks++;
    if (seen !== exp) begin
      fails++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // one apb transfer, waits for pready
  task automatic apb(input logic [11:0] a, input logic w,
                     output logic [31:0] rd, output logic er);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= r;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic do_reset();
    presetn <= 1'b0;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    repeat (3) @(posedge pclk);
  endtask

  task automatic complete_run();
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////
  // clock and watchdog
  initial begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end

  initial begin
    #100000;
    fails++;
    complete_run();
  end

  ////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    {presetn, erase_done, ext_prog_read_req, ext_eeprom_req} = '0;
    {watchdog_active, halt_entry, psel, penable, pwrite} = '0;
    paddr = '0;
    pwdata = '0;
    r = 32'hf954;
    fails = 0;
    total_checks = 0;
    cur0 = 8'hFF;
    cur1 = 8'hFF;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    repeat (3) @(posedge pclk);
    chk(prog_rdata, 8'hFF, "blank byte");
    chk(32'(cfg), 32'(exp_cfg(8'hFF, 8'hFF)), "blank cfg");
    apb(CONFIG_OFFSET, 1'b0, d, e);
    chk(d, 32'h0000FFFF, "config");
    apb(STATUS_OFFSET, 1'b0, d, e);
    chk(d[0], 1'b1, "running");
    apb(RAW_OFFSET, 1'b0, d, e);
    chk(d, 32'h0, "raw hidden");
    apb(12'h00C, 1'b0, d, e);
    chk(e, 1'b1, "unmapped");
    apb(CONFIG_OFFSET, 1'b1, d, e);
    chk(e, 1'b1, "bus write");
    for (int i = 0; i < 8; i++) begin
      r = xs(r);
      k = i[2:0];
      b0 = {6'h3F, r[1], k[0]};
      b1 = {r[7], k, k[1:0], r[3:2]};
      option_byte_prog_tool_inst.write_byte(1'b1, 1'b0, b0);
      chk(prog_rdata, b0, "byte0");
      chk(erase_req, cur0[0] & !b0[0], "erase");
      if (erase_req === 1'b1) begin
        erase_done <= 1'b1;
        @(posedge pclk);
        erase_done <= 1'b0;
        @(posedge pclk);
        chk(erase_req, 1'b0, "erase end");
        chk(prog_rdata, b0, "kept byte0");
      end
      option_byte_prog_tool_inst.write_byte(1'b1, 1'b1, b1);
      chk(prog_rdata, b1, "byte1");
      chk(32'(cfg), 32'(exp_cfg(cur0, cur1)), "held");
      cur0 = b0;
      cur1 = b1;
      do_reset();
      chk(32'(cfg), 32'(exp_cfg(cur0, cur1)), "cfg");
      apb(CONFIG_OFFSET, 1'b0, d, e);
      chk(d, {16'h0, cur1, cur0}, "config");
      ext_prog_read_req <= r[8];
      ext_eeprom_req <= r[9];
      watchdog_active <= r[10] | k[0];
      halt_entry <= r[11] | k[1];
      @(posedge pclk);
      chk(ext_prog_read_allow, r[8] & !cur0[0], "read gate");
      chk(ext_eeprom_allow, r[9], "eeprom");
      chk(halt_reset_req, (r[10] | k[0]) & (r[11] | k[1]) & cur1[1],
          "halt");
    end
    option_byte_prog_tool_inst.write_byte(1'b0, 1'b0, 8'hFC);
    chk(prog_rdata, cur0, "inactive write");
    complete_run();
  end
endmodule
